// >>> core/mhcb_bit_clock.sv
// Bit-rate enable divider of the holding-register configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "mhcb_cfg.svh"

module mhcb_bit_clock (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Selected rate code
    input wire logic [2:0] rateCode,
    // One-cycle enable per bit time
    output logic bitTick
);

    logic [15:0] count_q;

    // ==========================================
    // Cycles per bit for each rate code
    function automatic logic [15:0] bitCycles(input logic [2:0] code);
        logic [63:0] rate;
        rate = `MHCB_RATE_2;
        unique case (code)
            3'h0: rate = `MHCB_RATE_0;
            3'h1: rate = `MHCB_RATE_1;
            3'h2: rate = `MHCB_RATE_2;
            3'h3: rate = `MHCB_RATE_3;
            3'h4: rate = `MHCB_RATE_4;
            3'h5: rate = `MHCB_RATE_5;
            default: rate = `MHCB_RATE_2;
        endcase
        return 16'(`MHCB_CLK_HZ / rate);
    endfunction : bitCycles

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
            bitTick <= 1'b0;
        end else if (count_q >= bitCycles(rateCode) - 16'h0001) begin
            count_q <= 16'h0000; // RULE_01
            bitTick <= 1'b1;
        end else begin
            count_q <= count_q + 16'h0001;
            bitTick <= 1'b0;
        end
    end

endmodule : mhcb_bit_clock
`default_nettype wire

// >>> core/mhcb_cfg.svh
// Constants of the holding-register configuration bank
`ifndef MHCB_CFG_SVH
`define MHCB_CFG_SVH

// ==========================================
// Holding register numbers
`define MHCB_REG_STATION 16'h0001
`define MHCB_REG_BITRATE 16'h0002
`define MHCB_REG_PARITY 16'h0003
`define MHCB_REG_PRODUCT 16'h0004
`define MHCB_REG_HWREV 16'h0005
`define MHCB_REG_FWREV 16'h0006
`define MHCB_REG_RESERVED 16'h0007
`define MHCB_REG_TIMEOUT 16'h0008
`define MHCB_REG_TERM 16'h0009
`define MHCB_REG_RESTORE 16'h000A
`define MHCB_REG_LOWALARM 16'h000B

// ==========================================
// Factory defaults
`define MHCB_DEF_STATION 8'h01
`define MHCB_DEF_BITRATE 3'h2
`define MHCB_DEF_PARITY 2'h1
`define MHCB_DEF_TIMEOUT 6'h00
`define MHCB_DEF_TERM 1'b0
`define MHCB_DEF_LOWALARM 16'h0000

// ==========================================
// Legal ranges
`define MHCB_STATION_MIN 16'h0001
`define MHCB_STATION_MAX 16'h00F7
`define MHCB_BITRATE_MAX 16'h0005
`define MHCB_PARITY_MAX 16'h0002
`define MHCB_TIMEOUT_MAX 16'h003C
`define MHCB_TERM_MAX 16'h0001
`define MHCB_RESTORE_GO 16'h0001

// ==========================================
// Timing
`define MHCB_CLK_HZ 64'd50_000_000
`define MHCB_MINUTE_S 64'd60
`define MHCB_MINUTE_CYCLES (`MHCB_MINUTE_S * `MHCB_CLK_HZ)
`define MHCB_RATE_0 64'd4800
`define MHCB_RATE_1 64'd9600
`define MHCB_RATE_2 64'd19200
`define MHCB_RATE_3 64'd38400
`define MHCB_RATE_4 64'd57600
`define MHCB_RATE_5 64'd115200

`endif

// >>> core/mhcb_holding_bank.sv
// Holding-register configuration bank with comm-loss watchdog
`timescale 1ns/100ps
`default_nettype none
`include "mhcb_cfg.svh"

// Functional notes
// RULE_01: Bit-rate code 0..5 selects 4800..115200, default 2
// RULE_02: Product type code is read only
// RULE_03: Hardware revision read only, major/minor bytes
// RULE_04: Firmware revision read only, same layout
// RULE_05: Idle timeout minutes zeroes outputs; 0 disables
// RULE_06: Termination select 1 connects the resistor
// RULE_07: Writing 1 restores all factory defaults
// RULE_08: Restore command clears itself when done
// RULE_09: Low alarm above setpoint is rejected
// RULE_10: Station address 1..247 only, default 1
// RULE_11: Eight data bits, one stop, parity code
module mhcb_holding_bank #(
    parameter logic [15:0] PRODUCT_TYPE = 16'h0ABC, // Arbitrary value
    parameter logic [15:0] HW_REVISION = 16'h0301, // Arbitrary value
    parameter logic [15:0] FW_REVISION = 16'h0403, // Arbitrary value
    parameter logic [31:0] MINUTE_CYCLES = 32'(`MHCB_MINUTE_CYCLES)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register access from the frame layer
    input wire logic reqValid,
    input wire mhcb_pkg::mhcb_req_t req,
    output logic rspValid_q,
    output logic [15:0] rspData_q,
    output logic rspError_q,
    // Line activity and setpoint
    input wire logic frameSeen,
    input wire logic [7:0] rxStation,
    input wire logic signed [15:0] pressureSetpoint,
    // Line settings and controls
    output mhcb_pkg::mhcb_cfg_t cfg_q,
    output logic bitTick,
    output logic stationHit_q,
    output logic forceZero_q,
    output logic signed [15:0] lowAlarm_q,
    output logic restoreCmd_q
);

    logic restorePending_q;
    logic writeOk;
    logic [5:0] idleMin_q;
    logic [31:0] preCnt_q;

    // ==========================================
    // Write acceptance per register
    function automatic logic acceptWrite(input mhcb_pkg::mhcb_req_t r,
                                         input logic signed [15:0] setpoint);
        logic ok;
        ok = 1'b0;
        unique case (r.addr)
            `MHCB_REG_STATION: ok = (r.data >= `MHCB_STATION_MIN) &&
                                    (r.data <= `MHCB_STATION_MAX);
            `MHCB_REG_BITRATE: ok = (r.data <= `MHCB_BITRATE_MAX);
            `MHCB_REG_PARITY: ok = (r.data <= `MHCB_PARITY_MAX);
            `MHCB_REG_TIMEOUT: ok = (r.data <= `MHCB_TIMEOUT_MAX);
            `MHCB_REG_TERM: ok = (r.data <= `MHCB_TERM_MAX);
            `MHCB_REG_RESTORE: ok = (r.data <= `MHCB_RESTORE_GO);
            `MHCB_REG_LOWALARM: ok = !r.data[15] && ($signed(r.data) <= setpoint);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : acceptWrite

    assign writeOk = reqValid && req.write && acceptWrite(req, pressureSetpoint);

    // ==========================================
    // Writable registers and factory restore
    always_ff @(posedge clk_sys) begin
        if (!rst_n || restorePending_q) begin
            cfg_q.station <= `MHCB_DEF_STATION; // RULE_07
            cfg_q.bitRate <= `MHCB_DEF_BITRATE;
            cfg_q.parity <= mhcb_pkg::mhcb_parity_t'(`MHCB_DEF_PARITY);
            cfg_q.timeoutMin <= `MHCB_DEF_TIMEOUT;
            cfg_q.termination <= `MHCB_DEF_TERM;
            lowAlarm_q <= `MHCB_DEF_LOWALARM;
            restoreCmd_q <= 1'b0; // RULE_08
            restorePending_q <= 1'b0;
        end else if (writeOk) begin
            unique case (req.addr)
                `MHCB_REG_STATION: cfg_q.station <= req.data[7:0]; // RULE_10
                `MHCB_REG_BITRATE: cfg_q.bitRate <= req.data[2:0]; // RULE_01
                `MHCB_REG_PARITY: cfg_q.parity <= mhcb_pkg::mhcb_parity_t'(req.data[1:0]); // RULE_11
                `MHCB_REG_TIMEOUT: cfg_q.timeoutMin <= req.data[5:0]; // RULE_05
                `MHCB_REG_TERM: cfg_q.termination <= req.data[0]; // RULE_06
                `MHCB_REG_LOWALARM: lowAlarm_q <= req.data; // RULE_09
                default: begin
                    restoreCmd_q <= req.data[0]; // RULE_07
                    restorePending_q <= req.data[0];
                end
            endcase
        end
    end

    // ==========================================
    // Read path and answer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rspValid_q <= 1'b0;
            rspData_q <= 16'h0000;
            rspError_q <= 1'b0;
        end else begin
            rspValid_q <= reqValid;
            rspError_q <= reqValid && req.write && !writeOk; // RULE_02
            rspData_q <= 16'h0000;
            if (reqValid && !req.write) begin
                unique case (req.addr)
                    `MHCB_REG_STATION: rspData_q <= {8'h00, cfg_q.station};
                    `MHCB_REG_BITRATE: rspData_q <= {13'h0000, cfg_q.bitRate};
                    `MHCB_REG_PARITY: rspData_q <= {14'h0000, cfg_q.parity};
                    `MHCB_REG_PRODUCT: rspData_q <= PRODUCT_TYPE; // RULE_02
                    `MHCB_REG_HWREV: rspData_q <= HW_REVISION; // RULE_03
                    `MHCB_REG_FWREV: rspData_q <= FW_REVISION; // RULE_04
                    `MHCB_REG_TIMEOUT: rspData_q <= {10'h000, cfg_q.timeoutMin};
                    `MHCB_REG_TERM: rspData_q <= {15'h0000, cfg_q.termination};
                    `MHCB_REG_RESTORE: rspData_q <= {15'h0000, restoreCmd_q};
                    `MHCB_REG_LOWALARM: rspData_q <= lowAlarm_q;
                    default: begin
                        rspData_q <= 16'h0000;
                        rspError_q <= (req.addr != `MHCB_REG_RESERVED);
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Station match
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stationHit_q <= 1'b0;
        end else begin
            stationHit_q <= (rxStation == cfg_q.station); // RULE_10
        end
    end

    // ==========================================
    // Communication-loss watchdog
    always_ff @(posedge clk_sys) begin
        if (!rst_n || frameSeen || cfg_q.timeoutMin == 6'h00) begin
            preCnt_q <= 32'h0000_0000; // RULE_05
            idleMin_q <= 6'h00;
            forceZero_q <= 1'b0;
        end else if (idleMin_q >= cfg_q.timeoutMin) begin
            forceZero_q <= 1'b1; // RULE_05
        end else if (preCnt_q >= MINUTE_CYCLES - 32'h0000_0001) begin
            preCnt_q <= 32'h0000_0000;
            idleMin_q <= idleMin_q + 6'h01;
        end else begin
            preCnt_q <= preCnt_q + 32'h0000_0001;
        end
    end

    // ==========================================
    // Bit-rate enable
    mhcb_bit_clock u_bit_clock (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rateCode(cfg_q.bitRate),
        .bitTick(bitTick)
    );

    // ==========================================
    // Checks
    property p_answer;
        @(posedge clk_sys) disable iff (!rst_n) reqValid |=> rspValid_q;
    endproperty
    a_answer: assert property (p_answer) else $error("No answer after request");

    property p_read_only;
        @(posedge clk_sys) disable iff (!rst_n)
            reqValid && req.write && req.addr == `MHCB_REG_PRODUCT |=> rspError_q;
    endproperty
    a_read_only: assert property (p_read_only) else $error("Read-only write accepted"); // RULE_02

    property p_rate_reject;
        @(posedge clk_sys) disable iff (!rst_n)
            reqValid && req.write && req.addr == `MHCB_REG_BITRATE && req.data > 16'h0005
            && !restorePending_q |=> $stable(cfg_q.bitRate) && rspError_q;
    endproperty
    a_rate_reject: assert property (p_rate_reject) else $error("Bad rate code taken"); // RULE_01

    property p_restore;
        @(posedge clk_sys) disable iff (!rst_n)
            writeOk && req.addr == `MHCB_REG_RESTORE && req.data == 16'h0001 && !restorePending_q
            |=> restoreCmd_q ##1 (!restoreCmd_q && cfg_q.bitRate == 3'h2 && lowAlarm_q == 16'h0000);
    endproperty
    a_restore: assert property (p_restore) else $error("Restore did not complete"); // RULE_08

    property p_alarm_reject;
        @(posedge clk_sys) disable iff (!rst_n)
            reqValid && req.write && req.addr == `MHCB_REG_LOWALARM
            && $signed(req.data) > pressureSetpoint && !restorePending_q |=> $stable(lowAlarm_q);
    endproperty
    a_alarm_reject: assert property (p_alarm_reject) else $error("Alarm above setpoint taken"); // RULE_09

    property p_station_range;
        @(posedge clk_sys) disable iff (!rst_n)
            reqValid && req.write && req.addr == `MHCB_REG_STATION
            && (req.data == 16'h0000 || req.data > 16'h00F7) |=> rspError_q;
    endproperty
    a_station_range: assert property (p_station_range) else $error("Bad station taken"); // RULE_10

    property p_parity_reject;
        @(posedge clk_sys) disable iff (!rst_n)
            reqValid && req.write && req.addr == `MHCB_REG_PARITY && req.data > 16'h0002
            && !restorePending_q |=> $stable(cfg_q.parity);
    endproperty
    a_parity_reject: assert property (p_parity_reject) else $error("Bad parity taken"); // RULE_11

    property p_timeout_off;
        @(posedge clk_sys) disable iff (!rst_n)
            cfg_q.timeoutMin == 6'h00 |=> !forceZero_q;
    endproperty
    a_timeout_off: assert property (p_timeout_off) else $error("Outputs zeroed while disabled"); // RULE_05

    property p_traffic_clears;
        @(posedge clk_sys) disable iff (!rst_n)
            frameSeen |=> !forceZero_q ##1 !forceZero_q;
    endproperty
    a_traffic_clears: assert property (p_traffic_clears) else $error("Traffic did not clear"); // RULE_05

endmodule : mhcb_holding_bank
`default_nettype wire

// >>> core/mhcb_pkg.sv
// Types of the holding-register configuration bank
package mhcb_pkg;

    // ==========================================
    // Register access request
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [15:0] data;
    } mhcb_req_t;

    // ==========================================
    // Parity modes
    typedef enum logic [1:0] {
        MHCB_PAR_NONE = 2'h0,
        MHCB_PAR_EVEN = 2'h1,
        MHCB_PAR_ODD = 2'h2
    } mhcb_parity_t;

    // ==========================================
    // Communication settings seen by the line logic
    typedef struct packed {
        logic [7:0] station;
        logic [2:0] bitRate;
        mhcb_parity_t parity;
        logic [5:0] timeoutMin;
        logic termination;
    } mhcb_cfg_t;

endpackage : mhcb_pkg

// >>> verif/mhcb_master_model.sv
// Frame-layer master model that issues register requests to the bank
`timescale 1ns/100ps
`default_nettype none
module mhcb_master_model (
    // Clock
    input wire logic clk_sys,
    // Requests and line activity
    output logic reqValid,
    output mhcb_pkg::mhcb_req_t req,
    output logic frameSeen,
    output logic [7:0] rxStation,
    // Answers
    input wire logic rspValid_q,
    input wire logic [15:0] rspData_q,
    input wire logic rspError_q
);
    initial begin
        reqValid = 1'b0;
        req = '0;
        frameSeen = 1'b0;
        rxStation = 8'h00;
    end

    // ==========================================
    // One request taken at a single edge, answer sampled one cycle on
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                          output logic ok, output logic [15:0] rd, output logic er);
        @(negedge clk_sys);
        reqValid = 1'b1;
        req = '{write: wr, addr: addr, data: data};
        @(negedge clk_sys);
        reqValid = 1'b0;
        ok = rspValid_q;
        rd = rspData_q;
        er = rspError_q;
        // Released lines show a changed pattern, never the last value
        req = ~req;
    endtask : access

    // ==========================================
    // One received frame addressed to a station
    task automatic frame(input logic [7:0] station);
        @(negedge clk_sys);
        frameSeen = 1'b1;
        rxStation = station;
        @(negedge clk_sys);
        frameSeen = 1'b0;
        // Station lines are not held once the frame is over
        rxStation = ~station;
    endtask : frame
endmodule : mhcb_master_model
`default_nettype wire

// >>> verif/tb.sv
// Self-checking testbench of the holding-register configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "mhcb_cfg.svh"
`define CHK(act, exp) begin nChecks++; if ((act) !== (exp)) begin errCount++; \
    $display("ERROR t=%0t mismatch got %h exp %h", $time, act, exp); end end
module tb;
    localparam logic [15:0] PTYPE = 16'h5A5A; // Arbitrary value
    localparam logic [15:0] HWREV = 16'h0305; // Arbitrary value
    localparam logic [15:0] FWREV = 16'h0407; // Arbitrary value
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reqValid, frameSeen, rspValid_q, rspError_q, bitTick, stationHit_q;
    logic forceZero_q, restoreCmd_q;
    mhcb_pkg::mhcb_req_t req;
    logic [7:0] rxStation;
    logic [15:0] rspData_q;
    logic signed [15:0] pressureSetpoint = 16'sd100;
    logic signed [15:0] lowAlarm_q;
    mhcb_pkg::mhcb_cfg_t cfg_q, cfgDef;
    int errCount = 0;
    int nChecks = 0;
    int cycles = 0;
    int cnt;

    always #10 clk_sys = ~clk_sys;

    mhcb_master_model mst (.clk_sys(clk_sys), .reqValid(reqValid), .req(req),
        .frameSeen(frameSeen), .rxStation(rxStation), .rspValid_q(rspValid_q),
        .rspData_q(rspData_q), .rspError_q(rspError_q));

    mhcb_holding_bank #(.PRODUCT_TYPE(PTYPE), .HW_REVISION(HWREV), .FW_REVISION(FWREV),
        .MINUTE_CYCLES(32'd10)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .reqValid(reqValid), .req(req), .rspValid_q(rspValid_q), .rspData_q(rspData_q),
        .rspError_q(rspError_q), .frameSeen(frameSeen), .rxStation(rxStation),
        .pressureSetpoint(pressureSetpoint), .cfg_q(cfg_q), .bitTick(bitTick),
        .stationHit_q(stationHit_q), .forceZero_q(forceZero_q), .lowAlarm_q(lowAlarm_q),
        .restoreCmd_q(restoreCmd_q));

    // ==========================================
    // Access helpers
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
        logic ok;
        logic er;
        logic [15:0] rd;
        mst.access(1'b1, a, d, ok, rd, er);
        `CHK(ok, 1'b1)
        `CHK(er, e)
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] d, input logic e);
        logic ok;
        logic er;
        logic [15:0] v;
        mst.access(1'b0, a, 16'h0000, ok, v, er);
        `CHK(ok, 1'b1)
        `CHK(er, e)
        `CHK(v, d)
    endtask : rd

    task automatic final_report();
        $display("Checks %0d, errors %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            final_report();
        end
    end

    // ==========================================
    // Scenarios
    initial begin
        cfgDef = '{station: 8'h01, bitRate: 3'h2, parity: mhcb_pkg::MHCB_PAR_EVEN,
                   timeoutMin: 6'h00, termination: 1'b0};
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        rd(16'h0001, 16'h0001, 1'b0);
        rd(16'h0002, 16'h0002, 1'b0);
        rd(16'h0003, 16'h0001, 1'b0);
        rd(16'h0008, 16'h0000, 1'b0);
        rd(16'h0009, 16'h0000, 1'b0);
        rd(16'h000A, 16'h0000, 1'b0);
        rd(16'h000B, 16'h0000, 1'b0);
        rd(16'h0007, 16'h0000, 1'b0);
        rd(16'h000C, 16'h0000, 1'b1);
        wr(16'h0007, 16'h0001, 1'b1);
        wr(16'h0004, 16'hFFFF, 1'b1);
        rd(16'h0004, PTYPE, 1'b0);
        wr(16'h0005, 16'h0000, 1'b1);
        rd(16'h0005, HWREV, 1'b0);
        wr(16'h0006, 16'h0000, 1'b1);
        rd(16'h0006, FWREV, 1'b0);
        for (int i = 0; i < 6; i++) begin
            wr(16'h0002, 16'(i), 1'b0);
            `CHK(cfg_q.bitRate, 3'(i))
        end
        wr(16'h0002, 16'h0006, 1'b1);
        `CHK(cfg_q.bitRate, 3'h5)
        // Bit period at the fastest rate, counted between two ticks
        cnt = 0;
        while (bitTick !== 1'b1 && cnt < 2000) begin
            @(negedge clk_sys);
            cnt++;
        end
        cnt = 0;
        do begin
            @(negedge clk_sys);
            cnt++;
        end while (bitTick !== 1'b1 && cnt < 2000);
        `CHK(cnt, 32'(`MHCB_CLK_HZ / `MHCB_RATE_5))
        for (int i = 0; i < 3; i++) begin
            wr(16'h0003, 16'(i), 1'b0);
            `CHK(cfg_q.parity, mhcb_pkg::mhcb_parity_t'(i))
        end
        wr(16'h0003, 16'h0003, 1'b1);
        wr(16'h0001, 16'h0000, 1'b1);
        wr(16'h0001, 16'h00F8, 1'b1);
        wr(16'h0001, 16'h00F7, 1'b0);
        `CHK(cfg_q.station, 8'hF7)
        mst.frame(8'hF7);
        `CHK(stationHit_q, 1'b1)
        mst.frame(8'h01);
        `CHK(stationHit_q, 1'b0)
        wr(16'h0009, 16'h0001, 1'b0);
        `CHK(cfg_q.termination, 1'b1)
        wr(16'h0009, 16'h0002, 1'b1);
        wr(16'h000B, 16'h0064, 1'b0);
        wr(16'h000B, 16'h0065, 1'b1);
        wr(16'h000B, 16'hFFFF, 1'b1);
        `CHK(lowAlarm_q, 16'sd100)
        // Lower setpoint moves the acceptance limit with it
        pressureSetpoint = 16'sd50;
        wr(16'h000B, 16'h0033, 1'b1);
        `CHK(lowAlarm_q, 16'sd100)
        wr(16'h000B, 16'h0032, 1'b0);
        `CHK(lowAlarm_q, 16'sd50)
        wr(16'h0008, 16'h003D, 1'b1);
        wr(16'h0008, 16'h0001, 1'b0);
        mst.frame(8'h01);
        repeat (8) @(negedge clk_sys);
        `CHK(forceZero_q, 1'b0)
        repeat (12) @(negedge clk_sys);
        `CHK(forceZero_q, 1'b1)
        mst.frame(8'h01);
        `CHK(forceZero_q, 1'b0)
        wr(16'h0008, 16'h0000, 1'b0);
        repeat (40) @(negedge clk_sys);
        `CHK(forceZero_q, 1'b0)
        wr(16'h0008, 16'h0005, 1'b0);
        `CHK(cfg_q.timeoutMin, 6'h05)
        wr(16'h000A, 16'h0002, 1'b1);
        wr(16'h000A, 16'h0001, 1'b0);
        `CHK(restoreCmd_q, 1'b1)
        @(negedge clk_sys);
        `CHK(restoreCmd_q, 1'b0)
        `CHK(cfg_q, cfgDef)
        `CHK(lowAlarm_q, 16'sd0)
        rd(16'h000A, 16'h0000, 1'b0);
        rd(16'h0001, 16'h0001, 1'b0);
        // Reset in mid-run brings the termination back to disconnected
        wr(16'h0009, 16'h0001, 1'b0);
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        `CHK(cfg_q.termination, 1'b0)
        rd(16'h0009, 16'h0000, 1'b0);
        final_report();
    end
endmodule : tb
`default_nettype wire
